// >>> dkm_keypad_mode.sv
/*
  Keypad operation-mode controller: Running, Programming and Alarm modes.
  Assumes keys and the remote-keypad detect are pins; trip, settings and
  running data come from logic on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module dkm_keypad_mode
  import dkm_pkg::*;
#(
  parameter int DEB_CYCLES = DEBOUNCE_CYCLES,
  parameter int ALT_CYCLES = ALTERNATE_CYCLES
)(
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic [KEY_NUM-1:0] keyPin,
  input  wire logic              remoteKeypadPin,
  input  wire logic              tripEvent,
  input  wire logic [CODE_W-1:0] tripCode,
  input  wire logic              causeCleared,
  input  wire logic              extRunCmd,
  input  wire logic [1:0]        menu_limiter_setting,
  input  wire logic              menuLimiterWrite,
  input  wire logic [1:0]        run_direction_setting,
  input  wire logic [INFO_W-1:0] runInfoData,
  output dkm_mode_e              opMode,
  output logic                   alarmActive,
  output logic                   motorRunFwd,
  output logic                   motorRunRev,
  output logic                   decelStop,
  output logic                   alarmRelease,
  output logic [2:0]             menuShown,
  output logic [2:0]             groupShown,
  output logic                   changedOnlyView,
  output logic [1:0]             alarmIndex,
  output logic [2:0]             infoItemSel,
  output logic [31:0]            dispText,
  output logic [3:0]             dispDp,
  output logic [INFO_W-1:0]      dispValue,
  output logic                   dispShowValue
);
  localparam int IW = $clog2(INFO_ITEMS);
  localparam int HW = $clog2(HIST_DEPTH);
  localparam int AW = HW + IW;
  localparam int ACW = $clog2(ALT_CYCLES + 1);

  dkm_key_if #(.N(KEY_NUM)) keys ();
  dkm_hist_if #(.AW(AW), .DW(INFO_W)) hist ();

  dkm_key_filter #(.DEB_CYCLES(DEB_CYCLES)) uKeys (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .keyPin  (keyPin),
    .keys    (keys)
  );

  dkm_hist_mem #(.AW(AW), .DW(INFO_W)) uHist (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .port    (hist)
  );

  dkm_mode_e       mode_ff;
  dkm_mode_e       nxt_mode;
  logic            alarm_ff;
  logic [2:0]      menu_ff;
  logic [2:0]      group_ff;
  logic [HW-1:0]   histIdx_ff;
  logic [IW-1:0]   item_ff;
  logic [1:0]      limiter_ff;
  logic            runFwd_ff;
  logic            runRev_ff;
  logic            decel_ff;
  logic            release_ff;
  logic            remSync1_ff;
  logic            remSync2_ff;
  logic            capBusy_ff;
  logic [IW-1:0]   capItem_ff;
  logic [HW-1:0]   newest_ff;
  logic [CODE_W-1:0] code_ff [HIST_DEPTH];
  logic [ACW-1:0]  altCnt_ff;
  logic            showVal_ff;
  logic [31:0]     text_ff;

  function automatic logic [2:0] step_cyc(input logic [2:0] v, input logic up, input logic [2:0] lo,
                                          input logic [2:0] hi);
    if (up)
      step_cyc = (v >= hi) ? lo : v + 3'h1;
    else
      step_cyc = (v <= lo) ? hi : v - 3'h1;
  endfunction

  wire pRun     = keys.keyPress[KEY_RUN];
  wire pStop    = keys.keyPress[KEY_STOP];
  wire pUp      = keys.keyPress[KEY_UP];
  wire pDown    = keys.keyPress[KEY_DOWN];
  wire pFunc    = keys.keyPress[KEY_FUNCTION_DATA_KEY];
  // program key while stop is held is the two-key move; alone it is plain
  wire comboPrg = keys.keyPress[KEY_PRG] & keys.keyLevel[KEY_STOP];
  wire plainPrg = keys.keyPress[KEY_PRG] & ~keys.keyLevel[KEY_STOP];
  wire pStep    = pUp | pDown;
  wire inProg   = (mode_ff == MODE_PROG_MENU) || (mode_ff == MODE_PROG_DATA);
  wire copyOk   = remSync2_ff;
  wire [2:0] lastMenu = copyOk ? MENU_COPY : MENU_ALARM;
  // entry menu: limiter forces 1 or 2, full mode resumes last shown menu, or menu 1 if that is past lastMenu
  wire [2:0] entryMenu = (limiter_ff == LIMIT_DATA_SET)   ? MENU_SET :
                         (limiter_ff == LIMIT_DATA_CHECK) ? MENU_CHECK :
                         (menu_ff > lastMenu)             ? MENU_SET : menu_ff;
  wire canRelease = plainPrg && causeCleared && (histIdx_ff == '0);
  wire startReq = (pRun && mode_ff == MODE_RUN) || (release_ff && extRunCmd);
  wire dirRev   = (run_direction_setting == DIR_REV);
  wire [HW-1:0] physSlot = newest_ff - histIdx_ff;

  always_comb
  begin
    nxt_mode = mode_ff;
    if (tripEvent)
      nxt_mode = MODE_ALM_CODE;
    else
      case (mode_ff)
        MODE_RUN:       if (plainPrg) nxt_mode = MODE_PROG_MENU;
        MODE_PROG_MENU,
        MODE_PROG_DATA:
        begin
          if (plainPrg)
            nxt_mode = alarm_ff ? MODE_ALM_CODE : MODE_RUN;
          else if (pFunc && mode_ff == MODE_PROG_MENU)
            nxt_mode = MODE_PROG_DATA;
        end
        MODE_ALM_CODE:
        begin
          if (comboPrg)
            nxt_mode = MODE_PROG_MENU;
          else if (canRelease)
            nxt_mode = MODE_RUN;
          else if (pFunc)
            nxt_mode = MODE_ALM_INFO;
        end
        MODE_ALM_INFO:  if (plainPrg) nxt_mode = MODE_ALM_CODE;
        default:        nxt_mode = MODE_RUN;
      endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_ff     <= MODE_RUN;
      alarm_ff    <= 1'b0;
      release_ff  <= 1'b0;
      remSync1_ff <= 1'b0;
      remSync2_ff <= 1'b0;
      limiter_ff  <= LIMITER_RESET;
    end
    else
    begin
      mode_ff     <= nxt_mode;
      remSync1_ff <= remoteKeypadPin;
      remSync2_ff <= remSync1_ff;
      release_ff  <= !tripEvent && mode_ff == MODE_ALM_CODE && !comboPrg && canRelease;
      if (tripEvent)
        alarm_ff <= 1'b1;
      else if (mode_ff == MODE_ALM_CODE && !comboPrg && canRelease)
        alarm_ff <= 1'b0;
      if (menuLimiterWrite && menu_limiter_setting <= LIMIT_FULL)
        limiter_ff <= menu_limiter_setting;
    end
  end

  // menu, group, history and item cursors
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      menu_ff    <= MENU_SET;
      group_ff   <= '0;
      histIdx_ff <= '0;
      item_ff    <= '0;
    end
    else if (!tripEvent)
    begin
      if (nxt_mode == MODE_PROG_MENU && !inProg)
        menu_ff <= entryMenu;
      else if (mode_ff == MODE_PROG_MENU && pStep && !plainPrg && !pFunc && limiter_ff == LIMIT_FULL)
        menu_ff <= step_cyc(menu_ff, pUp, MENU_SET, lastMenu);
      if (mode_ff == MODE_PROG_DATA && menu_ff == MENU_SET && pStep)
        group_ff <= step_cyc(group_ff, pUp, 3'h0, 3'(GROUP_NUM - 1));
      if ((mode_ff == MODE_ALM_CODE || (mode_ff == MODE_PROG_DATA && menu_ff == MENU_ALARM)) && pStep
          && !plainPrg && !pFunc)
        histIdx_ff <= pUp ? histIdx_ff + 1'b1 : histIdx_ff - 1'b1;
      else if (mode_ff == MODE_ALM_INFO && plainPrg)
        histIdx_ff <= '0;
      if (mode_ff == MODE_ALM_CODE && pFunc)
        item_ff <= '0;
      else if (mode_ff == MODE_ALM_INFO && pStep && !plainPrg)
        item_ff <= pUp ? item_ff + 1'b1 : item_ff - 1'b1;
    end
    else
      histIdx_ff <= '0;
  end

  // run and stop; a trip drops the run command
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      runFwd_ff <= 1'b0;
      runRev_ff <= 1'b0;
      decel_ff  <= 1'b0;
    end
    else
    begin
      decel_ff <= pStop && (runFwd_ff || runRev_ff) && !tripEvent;
      if (tripEvent || pStop)
      begin
        runFwd_ff <= 1'b0;
        runRev_ff <= 1'b0;
      end
      else if (startReq)
      begin
        runFwd_ff <= !dirRev;
        runRev_ff <= dirRev;
      end
    end
  end

  // trip snapshot: code into the ring, running data one item per cycle
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      capBusy_ff <= 1'b0;
      capItem_ff <= '0;
      newest_ff  <= '0;
      for (int i = 0; i < HIST_DEPTH; i++) code_ff[i] <= '0;
    end
    else if (tripEvent)
    begin
      newest_ff                   <= newest_ff + 1'b1;
      code_ff[newest_ff + 1'b1]   <= tripCode;
      capBusy_ff                  <= 1'b1;
      capItem_ff                  <= '0;
    end
    else if (capBusy_ff)
    begin
      capItem_ff <= capItem_ff + 1'b1;
      if (capItem_ff == IW'(INFO_ITEMS - 1))
        capBusy_ff <= 1'b0;
    end
  end

  assign hist.wrEn   = capBusy_ff;
  assign hist.wrAddr = {newest_ff, capItem_ff};
  assign hist.wrData = runInfoData;
  assign hist.rdAddr = {physSlot, item_ff};

  // item number and value alternate at a slow rate
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      altCnt_ff  <= '0;
      showVal_ff <= 1'b0;
    end
    else if (mode_ff != MODE_ALM_INFO)
    begin
      altCnt_ff  <= '0;
      showVal_ff <= 1'b0;
    end
    else if (altCnt_ff == ACW'(ALT_CYCLES - 1))
    begin
      altCnt_ff  <= '0;
      showVal_ff <= !showVal_ff;
    end
    else
      altCnt_ff <= altCnt_ff + 1'b1;
  end

  wire [CODE_W-1:0] shownCode = code_ff[physSlot];
  wire [31:0] codeText = {CH_ZERO + 8'(histIdx_ff), CH_SPACE, dkm_hex_char(shownCode[7:4]),
                          dkm_hex_char(shownCode[3:0])};
  wire [31:0] itemText = {CH_SPACE, 8'h6e, CH_ZERO + 8'(item_ff), CH_SPACE};
  wire [31:0] nxtText  = inProg ? dkm_menu_label(menu_ff, group_ff) :
                         (mode_ff == MODE_ALM_CODE) ? codeText :
                         (mode_ff == MODE_ALM_INFO) ? itemText : {4{CH_SPACE}};

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      text_ff <= {4{CH_SPACE}};
    else
      text_ff <= nxtText;
  end

  assign opMode          = mode_ff;
  assign alarmActive     = alarm_ff;
  assign motorRunFwd     = runFwd_ff;
  assign motorRunRev     = runRev_ff;
  assign decelStop       = decel_ff;
  assign alarmRelease    = release_ff;
  assign menuShown       = menu_ff;
  assign groupShown      = group_ff;
  assign changedOnlyView = (mode_ff == MODE_PROG_DATA) && (menu_ff == MENU_CHECK);
  assign alarmIndex      = histIdx_ff;
  assign infoItemSel     = 3'(capItem_ff);
  assign dispText        = text_ff;
  assign dispDp          = inProg ? DP_LEFT : '0;
  assign dispValue       = hist.rdData;
  assign dispShowValue   = showVal_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence trip_seen;
    tripEvent ##1 (mode_ff == MODE_ALM_CODE && alarm_ff);
  endsequence

  trip_alarm_a: assert property (tripEvent |-> trip_seen)
    else $error("trip did not enter alarm mode");
  trip_capture_a: assert property (trip_seen |-> capBusy_ff [*7] ##1 (capBusy_ff || tripEvent))
    else $error("trip snapshot shorter than item count");
  run_ignored_a: assert property ((pRun && mode_ff != MODE_RUN && !release_ff)
                                  |=> !($rose(runFwd_ff) || $rose(runRev_ff)))
    else $error("run key acted outside running mode");
  rev_direction_a: assert property ((pRun && mode_ff == MODE_RUN && !tripEvent && !pStop
                                     && run_direction_setting == DIR_REV) |=> runRev_ff && !runFwd_ff)
    else $error("direction setting 3 did not run reverse");
  release_cond_a: assert property ($fell(alarm_ff) |-> $past(mode_ff) == MODE_ALM_CODE
                                   && $past(histIdx_ff) == '0 && $past(causeCleared) && alarmRelease)
    else $error("alarm released outside current code display");
  info_return_a: assert property ((mode_ff == MODE_ALM_INFO && plainPrg && !tripEvent)
                                  |=> mode_ff == MODE_ALM_CODE && alarm_ff && histIdx_ff == '0)
    else $error("program key in info view misbehaved");
  combo_prog_a: assert property ((mode_ff == MODE_ALM_CODE && comboPrg && !tripEvent)
                                 |=> mode_ff == MODE_PROG_MENU && alarm_ff)
    else $error("two-key press did not enter programming");
  menu_wrap_a: assert property ((mode_ff == MODE_PROG_MENU && limiter_ff == LIMIT_FULL && pUp
                                 && !plainPrg && !pFunc && !tripEvent && menu_ff == lastMenu)
                                |=> menu_ff == MENU_SET)
    else $error("menu did not wrap to the first");
  limiter_lock_a: assert property ((mode_ff == MODE_RUN && plainPrg && !tripEvent
                                    && limiter_ff == LIMIT_DATA_CHECK) |=> menu_ff == MENU_CHECK)
    else $error("limiter did not force data checking menu");

endmodule // dkm_keypad_mode

`default_nettype wire

// >>> dkm_pkg.sv
/*
  Shared constants, types and label helpers for the drive keypad mode controller.
  Assumes a single 25 MHz system clock.
*/
package dkm_pkg;

  localparam int CLK_HZ          = 25_000_000;
  localparam int DEBOUNCE_MS     = 10;
  localparam int DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int ALTERNATE_MS    = 500;
  localparam int ALTERNATE_CYCLES = CLK_HZ / 1000 * ALTERNATE_MS;

  localparam int KEY_NUM  = 6;
  localparam int KEY_RUN  = 0;
  localparam int KEY_STOP = 1;
  localparam int KEY_UP   = 2;
  localparam int KEY_DOWN = 3;
  localparam int KEY_PRG  = 4;
  localparam int KEY_FUNCTION_DATA_KEY = 5;

  localparam int HIST_DEPTH = 4;
  localparam int INFO_ITEMS = 8;
  localparam int INFO_W     = 16;
  localparam int CODE_W     = 8;
  localparam int GROUP_NUM  = 7;

  localparam logic [1:0] LIMIT_DATA_SET   = 2'h0;
  localparam logic [1:0] LIMIT_DATA_CHECK = 2'h1;
  localparam logic [1:0] LIMIT_FULL       = 2'h2;
  localparam logic [1:0] LIMITER_RESET    = LIMIT_DATA_SET;

  localparam logic [1:0] DIR_FWD = 2'h2;
  localparam logic [1:0] DIR_REV = 2'h3;

  localparam logic [2:0] MENU_SET   = 3'h1;
  localparam logic [2:0] MENU_CHECK = 3'h2;
  localparam logic [2:0] MENU_ALARM = 3'h6;
  localparam logic [2:0] MENU_COPY  = 3'h7;

  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [3:0] DP_LEFT  = 4'h8;

  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_PROG_MENU,
    MODE_PROG_DATA,
    MODE_ALM_CODE,
    MODE_ALM_INFO
  } dkm_mode_e;

  function automatic logic [7:0] dkm_hex_char(input logic [3:0] nib);
    dkm_hex_char = (nib < 4'ha) ? CH_ZERO + {4'h0, nib} : 8'h37 + {4'h0, nib};
  endfunction

  // leftmost digit is the menu number, the other three the contents code
  function automatic logic [31:0] dkm_menu_label(input logic [2:0] menu, input logic [2:0] grp);
    logic [23:0] tail;
    tail = {CH_SPACE, CH_SPACE, CH_SPACE};
    case (menu)
      3'h1:
      begin
        case (grp)
          3'h0: tail = {8'h46, CH_SPACE, CH_SPACE};
          3'h1: tail = {8'h45, CH_SPACE, CH_SPACE};
          3'h2: tail = {8'h43, CH_SPACE, CH_SPACE};
          3'h3: tail = {8'h50, CH_SPACE, CH_SPACE};
          3'h4: tail = {8'h48, CH_SPACE, CH_SPACE};
          3'h5: tail = {8'h4a, CH_SPACE, CH_SPACE};
          default: tail = {8'h79, CH_SPACE, CH_SPACE};
        endcase
      end
      3'h2: tail = {8'h72, 8'h45, 8'h50};
      3'h3: tail = {8'h6f, 8'h50, 8'h45};
      3'h4: tail = {8'h49, 8'h5f, 8'h6f};
      3'h5: tail = {8'h43, 8'h48, 8'h45};
      3'h6: tail = {8'h41, 8'h4c, CH_SPACE};
      3'h7: tail = {8'h43, 8'h50, 8'h79};
      default: tail = {CH_SPACE, CH_SPACE, CH_SPACE};
    endcase
    dkm_menu_label = {CH_ZERO + {5'h00, menu}, tail};
  endfunction

endpackage

// >>> dkm_if.sv
/*
  Interfaces between the mode controller and its key filter and history memory.
  Assumes all three modules share clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

interface dkm_key_if #(parameter int N = 6);
  logic [N-1:0] keyLevel;
  logic [N-1:0] keyPress;
  modport filt (output keyLevel, output keyPress);
  modport use_ (input keyLevel, input keyPress);
endinterface // dkm_key_if

interface dkm_hist_if #(parameter int AW = 5, parameter int DW = 16);
  logic          wrEn;
  logic [AW-1:0] wrAddr;
  logic [DW-1:0] wrData;
  logic [AW-1:0] rdAddr;
  logic [DW-1:0] rdData;
  modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
  modport mem (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface // dkm_hist_if

`default_nettype wire

// >>> dkm_key_filter.sv
/*
  Key synchroniser and debouncer: one press pulse per stable press.
  Assumes raw key pins asynchronous to clk_sys, active high.
*/
`timescale 1ns/1ps
`default_nettype none

module dkm_key_filter
  import dkm_pkg::*;
#(
  parameter int DEB_CYCLES = DEBOUNCE_CYCLES
)(
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  input  wire logic [KEY_NUM-1:0] keyPin,
  dkm_key_if.filt                 keys
);
  localparam int CW = $clog2(DEB_CYCLES + 1);

  logic [KEY_NUM-1:0] sync1_ff;
  logic [KEY_NUM-1:0] sync2_ff;
  logic [KEY_NUM-1:0] level_ff;
  logic [KEY_NUM-1:0] press_ff;
  logic [CW-1:0]      cnt_ff [KEY_NUM];

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= keyPin;
      sync2_ff <= sync1_ff;
    end
  end

  // a level must hold for the whole window before it is believed
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      level_ff <= '0;
      press_ff <= '0;
      for (int i = 0; i < KEY_NUM; i++) cnt_ff[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < KEY_NUM; i++)
      begin
        press_ff[i] <= 1'b0;
        if (sync2_ff[i] == level_ff[i])
          cnt_ff[i] <= '0;
        else if (cnt_ff[i] == CW'(DEB_CYCLES - 1))
        begin
          cnt_ff[i]   <= '0;
          level_ff[i] <= sync2_ff[i];
          press_ff[i] <= sync2_ff[i];
        end
        else
          cnt_ff[i] <= cnt_ff[i] + 1'b1;
      end
    end
  end

  assign keys.keyLevel = level_ff;
  assign keys.keyPress = press_ff;

endmodule // dkm_key_filter

`default_nettype wire

// >>> dkm_hist_mem.sv
/*
  Trip running-information store, one write and one registered read port.
  Assumes the controller owns both ports.
*/
`timescale 1ns/1ps
`default_nettype none

module dkm_hist_mem #(
  parameter int AW = 5,
  parameter int DW = 16
)(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  dkm_hist_if.mem   port
);
  logic [DW-1:0] store [2**AW];
  logic [DW-1:0] rdData_ff;

  always_ff @(posedge clk_sys)
  begin
    if (port.wrEn)
      store[port.wrAddr] <= port.wrData;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      rdData_ff <= '0;
    else
      rdData_ff <= store[port.rdAddr];
  end

  assign port.rdData = rdData_ff;

endmodule // dkm_hist_mem

`default_nettype wire

// >>> dkm_keypad_model.sv
/*
  Operator keypad model: presses, holds and releases keys on request.
  Assumes the controller filters the raw key levels on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module dkm_keypad_model
  import dkm_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic [31:0]        dispText,
  output logic      [KEY_NUM-1:0] keyPin
);
  // released keys read low: each switch has a pull-down
  initial keyPin = '0;

  // 12 cycles beats the filter's 4 + 2 edges, so each level is seen once
  task automatic hold(input int k, input logic lvl);
    @(posedge clk_sys);
    keyPin[k] <= lvl;
    repeat (12) @(posedge clk_sys);
  endtask

  task automatic press(input int k);
    hold(k, 1'b1);
    hold(k, 1'b0);
  endtask
endmodule // dkm_keypad_model

`default_nettype wire

// >>> drive_keypad_mode_controller_test.sv
/*
  Self-checking bench for the keypad mode controller.
  Assumes short filter counts in simulation and the keypad model beside it.
*/
`timescale 1ns/1ps
`default_nettype none

module drive_keypad_mode_controller_test
  import dkm_pkg::*;
;
  logic              clk_sys;
  logic              reset_n = 1'b0;
  wire  [5:0]        keyPin;
  logic              remotePin = 1'b0;
  logic              tripEvent = 1'b0;
  logic [7:0]        tripCode  = 8'h00;
  logic              causeCleared = 1'b0;
  logic              extRunCmd = 1'b0;
  logic [1:0]        limSet = 2'h0;
  logic              limWr  = 1'b0;
  logic [1:0]        dirSet = 2'h0;
  dkm_mode_e         opMode;
  logic              alarmActive, motorRunFwd, motorRunRev, decelStop, alarmRelease;
  logic [2:0]        menuShown;
  logic [2:0]        groupShown;
  logic              changedOnlyView;
  logic [3:0]        dispDp;
  logic [15:0]       dispValue;
  logic              dispShowValue;
  int                showCnt = 0;
  logic [1:0]        alarmIndex;
  logic [31:0]       dispText;
  int                mismatches = 0;
  int                num_checks = 0;
  int                decelCnt = 0;
  int                relCnt = 0;

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  dkm_keypad_mode #(.DEB_CYCLES(4), .ALT_CYCLES(8)) u_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .keyPin(keyPin), .remoteKeypadPin(remotePin),
    .tripEvent(tripEvent), .tripCode(tripCode), .causeCleared(causeCleared), .extRunCmd(extRunCmd),
    .menu_limiter_setting(limSet), .menuLimiterWrite(limWr), .run_direction_setting(dirSet),
    .runInfoData(16'h1234), .opMode(opMode), .alarmActive(alarmActive), .motorRunFwd(motorRunFwd),
    .motorRunRev(motorRunRev), .decelStop(decelStop), .alarmRelease(alarmRelease),
    .menuShown(menuShown), .groupShown(groupShown), .changedOnlyView(changedOnlyView),
    .alarmIndex(alarmIndex), .infoItemSel(), .dispText(dispText), .dispDp(dispDp),
    .dispValue(dispValue), .dispShowValue(dispShowValue));

  dkm_keypad_model u_kp (.clk_sys(clk_sys), .dispText(dispText), .keyPin(keyPin));

  // one-cycle pulses and cycles with the value shown are counted here so a scenario can judge them later
  always @(posedge clk_sys)
  begin
    if (decelStop === 1'b1) decelCnt++;
    if (alarmRelease === 1'b1) relCnt++;
    if (dispShowValue === 1'b1) showCnt++;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic lim_write(input logic [1:0] v);
    @(posedge clk_sys);
    limSet <= v;
    limWr  <= 1'b1;
    @(posedge clk_sys);
    limWr  <= 1'b0;
  endtask

  task automatic t_power_up();
    chk("opMode", MODE_RUN, opMode);
    chk("alarmActive", 0, alarmActive);
    chk("menuShown", MENU_SET, menuShown);
  endtask

  task automatic t_run_stop();
    u_kp.press(KEY_RUN);
    chk("motorRunFwd", 1, motorRunFwd);
    u_kp.press(KEY_STOP);
    chk("decelCnt", 1, decelCnt);
    chk("motorRunFwd", 0, motorRunFwd);
    @(posedge clk_sys) dirSet <= DIR_REV;
    u_kp.press(KEY_RUN);
    chk("motorRunRev", 1, motorRunRev);
    chk("motorRunFwd", 0, motorRunFwd);
    u_kp.press(KEY_STOP);
    @(posedge clk_sys) dirSet <= DIR_FWD;
    u_kp.press(KEY_RUN);
    chk("motorRunFwd", 1, motorRunFwd);
    u_kp.press(KEY_STOP);
  endtask

  task automatic t_menus();
    u_kp.press(KEY_PRG);
    chk("opMode", MODE_PROG_MENU, opMode);
    chk("dispTextLeft", 8'h31, dispText[31:24]);
    chk("dispDp", 4'h8, dispDp);
    u_kp.press(KEY_UP);
    chk("menuShown", MENU_SET, menuShown);
    u_kp.press(KEY_RUN);
    chk("motorRunFwd", 0, motorRunFwd);
    lim_write(2'h3);
    u_kp.press(KEY_UP);
    chk("menuShown", MENU_SET, menuShown);
    lim_write(LIMIT_FULL);
    u_kp.press(KEY_UP);
    chk("menuShown", MENU_CHECK, menuShown);
    chk("dispText", 32'h32724550, dispText);
    u_kp.press(KEY_FUNCTION_DATA_KEY);
    chk("changedOnlyView", 1, changedOnlyView);
    u_kp.press(KEY_PRG);
    chk("opMode", MODE_RUN, opMode);
    u_kp.press(KEY_PRG);
    chk("menuShown", MENU_CHECK, menuShown);
    u_kp.press(KEY_DOWN);
    u_kp.press(KEY_DOWN);
    chk("menuShown", MENU_ALARM, menuShown);
    chk("dispText", 32'h36414c20, dispText);
    @(posedge clk_sys) remotePin <= 1'b1;
    u_kp.press(KEY_UP);
    chk("menuShown", MENU_COPY, menuShown);
    u_kp.press(KEY_UP);
    chk("menuShown", MENU_SET, menuShown);
    u_kp.press(KEY_FUNCTION_DATA_KEY);
    u_kp.press(KEY_UP);
    chk("groupShown", 1, groupShown);
    chk("dispText", 32'h31452020, dispText);
    @(posedge clk_sys) remotePin <= 1'b0;
    u_kp.press(KEY_PRG);
  endtask

  task automatic t_alarm();
    @(posedge clk_sys);
    tripEvent <= 1'b1;
    tripCode  <= 8'h5a;
    @(posedge clk_sys) tripEvent <= 1'b0;
    @(posedge clk_sys);
    chk("opMode", MODE_ALM_CODE, opMode);
    chk("alarmActive", 1, alarmActive);
    repeat (2) @(posedge clk_sys);
    chk("dispText", 32'h30203541, dispText);
    u_kp.press(KEY_RUN);
    chk("motorRunFwd", 0, motorRunFwd);
    u_kp.press(KEY_UP);
    chk("alarmIndex", 1, alarmIndex);
    @(posedge clk_sys) causeCleared <= 1'b1;
    u_kp.press(KEY_PRG);
    chk("alarmActive", 1, alarmActive);
    @(posedge clk_sys) causeCleared <= 1'b0;
    u_kp.press(KEY_DOWN);
    chk("alarmIndex", 0, alarmIndex);
    u_kp.press(KEY_PRG);
    chk("alarmActive", 1, alarmActive);
    u_kp.press(KEY_FUNCTION_DATA_KEY);
    chk("opMode", MODE_ALM_INFO, opMode);
    chk("dispValue", 16'h1234, dispValue);
    chk("dispShowValue", 1, showCnt != 0);
    u_kp.press(KEY_UP);
    chk("dispTextItem", 8'h31, dispText[15:8]);
    u_kp.press(KEY_PRG);
    chk("opMode", MODE_ALM_CODE, opMode);
    u_kp.hold(KEY_STOP, 1'b1);
    u_kp.press(KEY_PRG);
    u_kp.hold(KEY_STOP, 1'b0);
    chk("opMode", MODE_PROG_MENU, opMode);
    chk("alarmActive", 1, alarmActive);
    u_kp.press(KEY_PRG);
    chk("opMode", MODE_ALM_CODE, opMode);
    @(posedge clk_sys);
    causeCleared <= 1'b1;
    extRunCmd    <= 1'b1;
    u_kp.press(KEY_FUNCTION_DATA_KEY);
    u_kp.press(KEY_PRG);
    chk("opMode", MODE_ALM_CODE, opMode);
    u_kp.press(KEY_PRG);
    chk("opMode", MODE_RUN, opMode);
    chk("alarmActive", 0, alarmActive);
    chk("relCnt", 1, relCnt);
    chk("motorRunFwd", 1, motorRunFwd);
    @(posedge clk_sys) extRunCmd <= 1'b0;
    u_kp.press(KEY_STOP);
  endtask

  initial
  begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_power_up();
    t_run_stop();
    t_menus();
    t_alarm();
    wrap_up();
  end

  // whole run needs roughly 1000 cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    wrap_up();
  end
endmodule // drive_keypad_mode_controller_test

`default_nettype wire
